// [hpmc_pkg.sv]
// Notes on behaviour
// - halt opcode enters full halt when osc irq enable is 0, timebase halt when 1.
// - timebase halt ends only on external irq, timebase irq, pending irq or reset.
// - interrupt wake from timebase halt has no delay; irq served as soon as condition codes are pushed.
// - reset wake from timebase halt inserts the stabilisation delay first.
// - entering timebase halt forces interrupt-level bits to 10.
// - timebase halt keeps only oscillator and timebase counter clocked.
// - with osc irq enable set, timebase halt never causes watchdog reset.
// - osc irq enable cleared in the wake-delay window after a timebase irq wake drops to full halt for remainder.
// - wake delay is 256 or 4096 cpu cycles, chosen by an option.
// - full halt stops the oscillator, cpu and peripheral clocks.
// - full halt exit on a wake input restarts oscillator and waits wake delay before resuming.
// - entering full halt by the halt opcode forces interrupt-level bits to 10.
// - watchdog sleep option, with the watchdog active, chooses watchdog reset instead of full halt.
// - before wake irq service, push condition codes and set level bits.
// - opcode 0x8E decodes as halt.
// - after the reset input the block starts in run state.
package hpmc_pkg;
  localparam logic [7:0]  HALT_OPCODE   = 8'h8e;
  localparam logic [1:0]  LEVEL_HALT    = 2'b10;
  localparam int          DELAY_SHORT   = 256;
  localparam int          DELAY_LONG    = 4096;
  localparam int          CNT_W         = 13;
  localparam logic [12:0] CNT_ZERO      = 13'h0000;

  typedef enum logic [1:0] {
    HPMC_CAUSE_NONE,
    HPMC_CAUSE_IRQ,
    HPMC_CAUSE_RESET
  } hpmc_cause_t;

  typedef enum logic [2:0] {
    HPMC_RUN,
    HPMC_FULL_HALT,
    HPMC_TB_HALT,
    HPMC_DELAY,
    HPMC_WAKE
  } hpmc_state_t;

  // gate and indication outputs toward the core and clock tree
  typedef struct packed {
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        osc_en;
    logic        timebase_clk_en;
    logic        level_force;
    logic        irq_service;
    logic        vector_fetch;
    logic        watchdog_reset;
    hpmc_cause_t wake_cause;
  } hpmc_ctl_t;

  function automatic logic [12:0] hpmc_delay_last(input logic long_sel);
    hpmc_delay_last = long_sel ? 13'(DELAY_LONG - 1) : 13'(DELAY_SHORT - 1);
  endfunction
endpackage

// [hpmc_sequencer.sv]
`timescale 1ns/1ns
module hpmc_sequencer #(
  parameter int DELAY_LONG_CYC = hpmc_pkg::DELAY_LONG
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       opcode_valid,
  input  wire logic [7:0] opcode,
  input  wire logic       osc_irq_enable,
  input  wire logic       watchdog_active,
  input  wire logic       watchdog_sleep_option,
  input  wire logic       long_delay_option,
  input  wire logic       ext_irq,
  input  wire logic       timebase_irq,
  input  wire logic       halt_irq,
  input  wire logic       wake_reset,
  input  wire logic       irq_pending,
  input  wire logic       ccr_pushed,
  output hpmc_pkg::hpmc_ctl_t ctl,
  output logic [1:0]      forced_level,
  output logic            halted
);
  import hpmc_pkg::*;

  typedef struct packed {
    hpmc_state_t     st;
    logic [12:0]     cnt;
    logic [12:0]     last;
    hpmc_cause_t     cause;
    logic            tb_origin;
    hpmc_ctl_t       out;
  } hpmc_reg_t;

  hpmc_reg_t r_q;
  hpmc_reg_t r_d;
  logic      halt_exec;
  logic [12:0] last_sel;

  assign halt_exec = opcode_valid && (opcode == HALT_OPCODE);
  // terminal count; long length is a parameter so sims can shorten it
  assign last_sel = long_delay_option ? 13'(DELAY_LONG_CYC - 1)
                                      : hpmc_delay_last(1'b0);

  // next state: one pass fills the whole copy of the state
  always_comb begin
    r_d = r_q;
    r_d.out.irq_service    = 1'b0;
    r_d.out.vector_fetch   = 1'b0;
    r_d.out.watchdog_reset = 1'b0;
    r_d.out.level_force    = 1'b0;
    case (r_q.st)
      HPMC_RUN: begin
        if (r_q.tb_origin && !osc_irq_enable) begin
          // enable dropped inside the guard window after a timebase wake
          r_d.st = HPMC_FULL_HALT;
        end else if (halt_exec) begin
          r_d.tb_origin = 1'b0; // a fresh halt ends any guard window
          if (osc_irq_enable) begin
            // no watchdog reset while the timebase keeps running
            r_d.st = HPMC_TB_HALT;
            r_d.out.level_force = 1'b1;
          end else if (watchdog_active && watchdog_sleep_option) begin
            r_d.out.watchdog_reset = 1'b1;
          end else begin
            r_d.st = HPMC_FULL_HALT;
            r_d.out.level_force = 1'b1;
          end
        end
      end
      HPMC_TB_HALT: begin
        // only these four causes leave timebase halt
        if (wake_reset) begin
          r_d.st = HPMC_DELAY;
          r_d.cause = HPMC_CAUSE_RESET;
          r_d.cnt = CNT_ZERO;
          r_d.last = last_sel;
          r_d.tb_origin = 1'b0;
        end else if (ext_irq || timebase_irq || irq_pending) begin
          r_d.st = HPMC_WAKE;
          r_d.cause = HPMC_CAUSE_IRQ;
          // guard window only follows a timebase wake
          r_d.cnt = CNT_ZERO;
          r_d.last = last_sel;
          r_d.tb_origin = timebase_irq;
        end
      end
      HPMC_FULL_HALT: begin
        if (r_q.tb_origin) begin
          // timed halt: wake inputs ignored until the window runs out
          if (r_q.cnt == r_q.last) begin
            r_d.st = HPMC_RUN;
          end
        end else if (wake_reset || halt_irq || irq_pending) begin
          r_d.st = HPMC_DELAY;
          r_d.cause = wake_reset ? HPMC_CAUSE_RESET : HPMC_CAUSE_IRQ;
          r_d.cnt = CNT_ZERO;
          r_d.last = last_sel;
          r_d.tb_origin = 1'b0;
        end
      end
      HPMC_DELAY: begin
        // count cpu cycles of the restarted oscillator
        if (r_q.cnt == r_q.last) begin
          r_d.st = HPMC_WAKE;
        end else begin
          r_d.cnt = 13'(r_q.cnt + 13'h0001);
        end
      end
      HPMC_WAKE: begin
        // core pushes condition codes before service starts
        if (r_q.cause == HPMC_CAUSE_RESET) begin
          r_d.out.vector_fetch = 1'b1;
          r_d.st = HPMC_RUN;
        end else if (ccr_pushed) begin
          r_d.out.irq_service = 1'b1;
          r_d.st = HPMC_RUN;
        end
      end
      default: r_d.st = HPMC_RUN;
    endcase

    // guard window counter; a newly opened window starts next cycle
    if (r_q.tb_origin && r_d.tb_origin) begin
      if (r_q.cnt == r_q.last) begin
        r_d.tb_origin = 1'b0;
      end else begin
        r_d.cnt = 13'(r_q.cnt + 13'h0001);
      end
    end

    // clock gates follow the next state so they are registered
    r_d.out.cpu_clk_en      = (r_d.st == HPMC_RUN) || (r_d.st == HPMC_WAKE);
    r_d.out.periph_clk_en   = r_d.out.cpu_clk_en;
    r_d.out.osc_en          = (r_d.st != HPMC_FULL_HALT);
    r_d.out.timebase_clk_en = r_d.out.osc_en;
    r_d.out.wake_cause      = (r_d.st == HPMC_RUN) ? HPMC_CAUSE_NONE
                                                   : r_d.cause;
  end

  // single register; reset lands in run with clocks on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_q.st                  <= HPMC_RUN;
      r_q.cnt                 <= CNT_ZERO;
      r_q.last                <= CNT_ZERO;
      r_q.cause               <= HPMC_CAUSE_NONE;
      r_q.tb_origin           <= 1'b0;
      r_q.out.cpu_clk_en      <= 1'b1;
      r_q.out.periph_clk_en   <= 1'b1;
      r_q.out.osc_en          <= 1'b1;
      r_q.out.timebase_clk_en <= 1'b1;
      r_q.out.level_force     <= 1'b0;
      r_q.out.irq_service     <= 1'b0;
      r_q.out.vector_fetch    <= 1'b0;
      r_q.out.watchdog_reset  <= 1'b0;
      r_q.out.wake_cause      <= HPMC_CAUSE_NONE;
    end else begin
      r_q <= r_d;
    end
  end

  assign ctl          = r_q.out;
  assign forced_level = LEVEL_HALT;
  assign halted       = (r_q.st == HPMC_FULL_HALT) ||
                        (r_q.st == HPMC_TB_HALT);
endmodule

// [hpmc_checker.sv]
`timescale 1ns/1ns
// sees sequencer ports only; short delay count gets a few cycles of slack
module hpmc_checker import hpmc_pkg::*; #(
  parameter int DELAY_LONG_CYC = DELAY_LONG
) (
  input wire logic       ref_clk, reset, opcode_valid, osc_irq_enable,
  input wire logic       watchdog_active, watchdog_sleep_option, ext_irq,
  input wire logic       long_delay_option, wake_reset, ccr_pushed, halted,
  input wire logic       timebase_irq,
  input wire logic [7:0] opcode,
  input wire logic [1:0] forced_level,
  input hpmc_pkg::hpmc_ctl_t ctl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // halt taken in run, watchdog choice, timebase halt
  wire go = opcode_valid && opcode == HALT_OPCODE && !halted &&
            ctl.cpu_clk_en && ctl.wake_cause == HPMC_CAUSE_NONE;
  wire wd = watchdog_active && watchdog_sleep_option;
  wire tb = halted && ctl.osc_en && !ctl.cpu_clk_en;
  halt_tb_a: assert property (go && osc_irq_enable |=> halted &&
    ctl.level_force && !ctl.cpu_clk_en && !ctl.watchdog_reset) else $error("tb");
  halt_full_a: assert property (go && !osc_irq_enable && !wd |=>
    !ctl.osc_en && !ctl.periph_clk_en && ctl.level_force) else $error("full");
  wdog_rst_a: assert property (go && !osc_irq_enable && wd |=>
    ctl.watchdog_reset && !halted) else $error("wdog");
  level_val_a: assert property (ctl.level_force |->
    forced_level == LEVEL_HALT) else $error("level");
  irq_wake_a: assert property (tb && ext_irq |=> ctl.cpu_clk_en &&
    ctl.wake_cause == HPMC_CAUSE_IRQ) else $error("irq wake");
  rst_delay_a: assert property (tb && wake_reset |=>
    (!ctl.cpu_clk_en) [*4]) else $error("rst wake");
  delay_len_a: assert property ($rose(ctl.osc_en) && !long_delay_option
    |-> ##250 !ctl.cpu_clk_en ##[1:8] ctl.cpu_clk_en) else $error("delay");
  svc_ccr_a: assert property (ctl.irq_service |-> $past(ccr_pushed) ||
    $past(ccr_pushed, 2)) else $error("service");
  tb_wake_a: assert property (tb && timebase_irq |=> ctl.cpu_clk_en &&
    ctl.wake_cause == HPMC_CAUSE_IRQ) else $error("timebase wake");
  halt_gate_a: assert property (halted |-> !ctl.cpu_clk_en &&
    !ctl.periph_clk_en) else $error("gates");
endmodule

// [hpmc_core_model.sv]
`timescale 1ns/1ns
// core side: pushes condition codes lag cycles into an irq wake, once unless lag is 15
module hpmc_core_model import hpmc_pkg::*; (
  input wire logic       ref_clk,
  input wire logic       reset,
  input hpmc_pkg::hpmc_ctl_t ctl,
  input wire logic [3:0] lag,
  output logic           ccr_pushed
);
  logic [3:0] cnt_q;
  wire go = ctl.wake_cause == HPMC_CAUSE_IRQ && ctl.cpu_clk_en;
  // saturating count so a lingering cause cannot push twice, unless lag is 15
  always_ff @(posedge ref_clk) begin
    ccr_pushed <= !reset && go && cnt_q == lag;
    cnt_q <= (reset || !go) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
  end
endmodule

// [halt_power_mode_control_tb_top.sv]
`timescale 1ns/1ns
module halt_power_mode_control_tb_top;
  import hpmc_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, opcode_valid = 1'b0, halted, ccr_pushed;
  logic osc_irq_enable = 1'b0, watchdog_active = 1'b0, ext_irq = 1'b0;
  logic watchdog_sleep_option = 1'b0, long_delay_option = 1'b0;
  logic timebase_irq = 1'b0, halt_irq = 1'b0, wake_reset = 1'b0;
  logic irq_pending = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [1:0] forced_level;
  logic [3:0] lag = 4'h0;
  hpmc_ctl_t  ctl;
  int         n_fail = 0, check_count = 0, n;
  // long delay shortened to 32 cycles to keep the run brief
  hpmc_sequencer #(.DELAY_LONG_CYC(32)) dut_u (.*);
  hpmc_core_model core_u (.*);
  always #25 ref_clk = ~ref_clk;
  task chk(input logic [3:0] s, input logic [3:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("fails %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one opcode; returns just after the edge that takes it
  task op(input logic [7:0] c);
    @(posedge ref_clk);
    opcode_valid <= 1'b1;
    opcode <= c;
    @(posedge ref_clk);
    opcode_valid <= 1'b0;
    #1;
  endtask
  // bounded wait: 0 cpu clock, 1 irq service, 2 vector fetch
  task wt(input int w);
    for (n = 0; (w == 0 ? ctl.cpu_clk_en : w == 1 ? ctl.irq_service
         : ctl.vector_fetch) !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
      n_fail += int'(n > 400);
      if (n > 400) stop_test;
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk({ctl.cpu_clk_en, ctl.periph_clk_en, ctl.osc_en, halted}, 4'he);
    watchdog_active <= 1'b1;
    watchdog_sleep_option <= 1'b1;
    op(8'h8f);
    chk(halted, 1'b0);
    op(HALT_OPCODE);
    chk({ctl.watchdog_reset, halted}, 4'h2);
    osc_irq_enable <= 1'b1;
    // external and timebase irq wakes from timebase halt, prompt and slow core
    for (int i = 0; i < 2; i++) begin
      lag <= 4'(i * 5);
      op(HALT_OPCODE);
      chk({halted, ctl.level_force, forced_level}, 4'he);
      chk({ctl.cpu_clk_en, ctl.periph_clk_en, ctl.osc_en}, 4'h1);
      halt_irq <= 1'b1;
      repeat (3) @(posedge ref_clk);
      halt_irq <= 1'b0;
      ext_irq <= (i == 0);
      timebase_irq <= (i == 1);
      #1;
      chk(halted, 1'b1);
      wt(0);
      ext_irq <= 1'b0;
      timebase_irq <= 1'b0;
      chk(n, 4'h1);
      chk(ctl.wake_cause, HPMC_CAUSE_IRQ);
      wt(1);
    end
    // enable cleared inside the guard window after the timebase wake
    osc_irq_enable <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({halted, ctl.osc_en}, 4'h2);
    wt(0);
    chk(n > 240 && n < 256, 1'b1);
    osc_irq_enable <= 1'b1;
    long_delay_option <= 1'b1;
    op(HALT_OPCODE);
    wake_reset <= 1'b1;
    @(posedge ref_clk);
    wake_reset <= 1'b0;
    wt(0);
    chk(n > 28 && n < 36, 1'b1);
    chk(ctl.wake_cause, HPMC_CAUSE_RESET);
    wt(2);
    {osc_irq_enable, watchdog_active, long_delay_option} <= 3'h0;
    op(HALT_OPCODE);
    chk({ctl.osc_en, ctl.cpu_clk_en, ctl.level_force}, 4'h1);
    halt_irq <= 1'b1;
    @(posedge ref_clk);
    halt_irq <= 1'b0;
    wt(0);
    chk(n > 252 && n < 260, 1'b1);
    wt(1);
    stop_test;
  end
endmodule
bind hpmc_sequencer hpmc_checker #(.DELAY_LONG_CYC(DELAY_LONG_CYC))
  chk_u (.*);
